// ### logic/dbguart_top.sv
// Debug UART: APB register file, status flags, test modes, serial engine.
`include "dbguart_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module dbguart_top (
  input  wire logic                      pclk,      // Master clock.
  input  wire logic                      presetn,   // Async reset, low.
  input  wire logic                      psel,      // APB select.
  input  wire logic                      penable,   // APB enable.
  input  wire logic                      pwrite,    // APB write.
  input  wire logic [11:0]               paddr,     // APB byte address.
  input  wire logic [31:0]               pwdata,    // APB write data.
  output logic [31:0]                    prdata,    // APB read data.
  output logic                           pready,    // APB ready.
  output logic                           pslverr,   // APB error.
  input  wire dbguart_pkg::dbguart_dma_s dma_in,    // DMA channel signals.
  input  wire dbguart_pkg::dbguart_dcc_s dcc_in,    // Debugger signals.
  input  wire logic                      serial_in_pin,  // Receive pin.
  output logic                           serial_out_pin, // Transmit pin.
  output logic                           irq        // Interrupt out.
);
  import dbguart_pkg::*;

  // ==========================================================
  // Declarations
  logic [31:0]     mask_reg;
  logic [31:0]     status;
  logic [2:0]      check_bit_type;
  dbguart_channel_loop_select_e channel_loop_select;
  logic [15:0]     baud_divisor;
  logic            rx_en_reg;
  logic            tx_en_reg;
  logic            receive_ready_flag;
  logic [7:0]      received_character;
  logic            thr_full_reg;
  logic [7:0]      character_to_send;
  logic            overrun_flag;
  logic            framing_flag;
  logic            check_bit_error_flag;
  logic            rx_meta_reg;
  logic            rx_sync_reg;
  logic            tick;
  logic            tx_busy;
  logic            tx_line;
  logic            rx_done;
  logic [7:0]      rx_data;
  logic            rx_frm_err;
  logic            rx_chk_err;
  logic            eng_rx_line;
  logic            eng_rx_abort;
  logic            eng_tx_abort;
  logic            tx_start;
  logic            wr_en;
  logic            rd_en;
  logic            ctrl_wr;
  logic            thr_wr;
  logic            rhr_rd;
  logic            mapped;
  logic            transmit_ready_flag;
  logic            transmitter_idle_flag;

  // ==========================================================
  // APB slave: zero wait state, unmapped addresses give an error.
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign ctrl_wr = wr_en && (paddr == `DU_OFF_CTRL);
  assign thr_wr  = wr_en && (paddr == `DU_OFF_TX_HOLD);
  assign rhr_rd  = rd_en && (paddr == `DU_OFF_RX_HOLD);

  always_comb
  begin
    if (paddr <= `DU_OFF_BAUD && paddr[1:0] == 2'b00)
      mapped = 1'b1;
    else
      mapped = 1'b0;
  end
  assign pslverr = psel && penable && !mapped;

  // Reads are decoded combinationally from register state and the DMA and debugger status inputs.
  always_comb
  begin
    if (!rd_en)
      prdata = 32'h00000000;
    else if (paddr == `DU_OFF_MODE)
      prdata = {16'h0000, channel_loop_select, 2'b00, check_bit_type,
                9'h000};
    else if (paddr == `DU_OFF_IRQ_MASK)
      prdata = mask_reg;
    else if (paddr == `DU_OFF_STATUS)
      prdata = status;
    else if (paddr == `DU_OFF_RX_HOLD)
      prdata = {24'h000000, received_character};
    else if (paddr == `DU_OFF_BAUD)
      prdata = {16'h0000, baud_divisor};
    else
      prdata = 32'h00000000;
  end

  // ==========================================================
  // Mode and baud registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      check_bit_type      <= `DU_MODE_RESET;
      channel_loop_select <= DU_CH_NORMAL;
    end
    else if (wr_en && paddr == `DU_OFF_MODE)
    begin
      check_bit_type      <= pwdata[`DU_MODE_PAR_LSB +: 3];
      channel_loop_select <=
        dbguart_channel_loop_select_e'(pwdata[`DU_MODE_CHM_LSB +: 2]);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      baud_divisor <= `DU_BAUD_RESET;
    else if (wr_en && paddr == `DU_OFF_BAUD)
      baud_divisor <= pwdata[15:0];
  end

  // ==========================================================
  // Interrupt mask: set by enable, cleared by disable writes.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_reg <= `DU_MASK_RESET;
    else if (wr_en && paddr == `DU_OFF_IRQ_EN)
      mask_reg <= mask_reg | (pwdata & `DU_SR_USED);
    else if (wr_en && paddr == `DU_OFF_IRQ_DIS)
      mask_reg <= mask_reg & ~pwdata;
  end

  assign irq = |(status & mask_reg);

  // ==========================================================
  // Receiver and transmitter enables from the control register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_en_reg <= 1'b0;
      tx_en_reg <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      if (pwdata[`DU_B_RX_RESET] || pwdata[`DU_B_RX_DIS])
        rx_en_reg <= 1'b0;
      else if (pwdata[`DU_B_RX_EN])
        rx_en_reg <= 1'b1;
      if (pwdata[`DU_B_TX_RESET] || pwdata[`DU_B_TX_DIS])
        tx_en_reg <= 1'b0;
      else if (pwdata[`DU_B_TX_EN])
        tx_en_reg <= 1'b1;
    end
  end

  // ==========================================================
  // Receive pin synchroniser.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end
    else
    begin
      rx_meta_reg <= serial_in_pin;
      rx_sync_reg <= rx_meta_reg;
    end
  end

  // ==========================================================
  // Test modes steer the engines and the output pin.
  assign eng_rx_line = (channel_loop_select == DU_CH_LOCAL) ? tx_line
                                                            : rx_sync_reg;
  assign eng_rx_abort = !rx_en_reg ||
                        (channel_loop_select == DU_CH_REMOTE);
  assign eng_tx_abort = (ctrl_wr && pwdata[`DU_B_TX_RESET]) ||
                        (channel_loop_select == DU_CH_REMOTE);

  always_comb
  begin
    case (channel_loop_select)
      DU_CH_ECHO:   serial_out_pin = rx_sync_reg;
      DU_CH_LOCAL:  serial_out_pin = 1'b1;
      DU_CH_REMOTE: serial_out_pin = rx_sync_reg;
      default:      serial_out_pin = tx_line;
    endcase
  end

  // ==========================================================
  // Transmit holding register feeds the shifter.
  assign tx_start = thr_full_reg && tx_en_reg && !tx_busy &&
                    (channel_loop_select != DU_CH_REMOTE);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      thr_full_reg      <= 1'b0;
      character_to_send <= 8'h00;
    end
    else if (ctrl_wr && pwdata[`DU_B_TX_RESET])
      thr_full_reg <= 1'b0;
    else if (thr_wr && tx_en_reg)
    begin
      thr_full_reg      <= 1'b1;
      character_to_send <= pwdata[7:0];
    end
    else if (tx_start)
      thr_full_reg <= 1'b0;
  end

  assign transmit_ready_flag   = tx_en_reg && !thr_full_reg;
  assign transmitter_idle_flag = tx_en_reg && !thr_full_reg &&
                                 !tx_busy;

  // ==========================================================
  // Receive holding register and flags; set wins over a read or status clear, but a receiver disable clears receive ready first.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      receive_ready_flag <= 1'b0;
      received_character <= 8'h00;
    end
    else if (!rx_en_reg)
      receive_ready_flag <= 1'b0;
    else if (rx_done)
    begin
      receive_ready_flag <= 1'b1;
      received_character <= rx_data;
    end
    else if (rhr_rd)
      receive_ready_flag <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      overrun_flag         <= 1'b0;
      framing_flag         <= 1'b0;
      check_bit_error_flag <= 1'b0;
    end
    else
    begin
      if (rx_done && rx_en_reg && receive_ready_flag && !rhr_rd)
        overrun_flag <= 1'b1;
      else if (ctrl_wr && pwdata[`DU_B_STA_CLR])
        overrun_flag <= 1'b0;
      if (rx_done && rx_en_reg && rx_frm_err)
        framing_flag <= 1'b1;
      else if (ctrl_wr && pwdata[`DU_B_STA_CLR])
        framing_flag <= 1'b0;
      if (rx_done && rx_en_reg && rx_chk_err)
        check_bit_error_flag <= 1'b1;
      else if (ctrl_wr && pwdata[`DU_B_STA_CLR])
        check_bit_error_flag <= 1'b0;
    end
  end

  // ==========================================================
  // Status word.
  always_comb
  begin
    status                 = 32'h00000000;
    status[`DU_SR_RECEIVE_READY_FLAG]   = receive_ready_flag;
    status[`DU_SR_TRANSMIT_READY_FLAG]   = transmit_ready_flag;
    status[`DU_SR_RXDONE]  = dma_in.rx_dma_done;
    status[`DU_SR_TXDONE]  = dma_in.tx_dma_done;
    status[`DU_SR_OVR]     = overrun_flag;
    status[`DU_SR_FRM]     = framing_flag;
    status[`DU_SR_CHK]     = check_bit_error_flag;
    status[`DU_SR_TXIDLE]  = transmitter_idle_flag;
    status[`DU_SR_TRANSMIT_BUFFER_EMPTY]  = dma_in.tx_dma_empty;
    status[`DU_SR_RECEIVE_BUFFER_FULL]  = dma_in.rx_dma_full;
    status[`DU_SR_DBGW]    = dcc_in.debugger_write_pending;
    status[`DU_SR_DBGR]    = dcc_in.debugger_read_pending;
  end

  // ==========================================================
  // Engines.
  dbguart_baud u_baud (
    .pclk    (pclk),
    .presetn (presetn),
    .divisor (baud_divisor),
    .tick    (tick)
  );

  dbguart_serial u_serial (
    .pclk       (pclk),
    .presetn    (presetn),
    .tick       (tick),
    .check_type (check_bit_type),
    .tx_start   (tx_start),
    .tx_data    (character_to_send),
    .tx_abort   (eng_tx_abort),
    .tx_busy    (tx_busy),
    .tx_line    (tx_line),
    .rx_line    (eng_rx_line),
    .rx_abort   (eng_rx_abort),
    .rx_done    (rx_done),
    .rx_data    (rx_data),
    .rx_frm_err (rx_frm_err),
    .rx_chk_err (rx_chk_err)
  );

  // ==========================================================
  // Checks.
  a_mask_set: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == `DU_OFF_IRQ_EN && pwdata[0] |=> mask_reg[0])
    else $error("enable write did not set mask bit");
  a_mask_clear: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == `DU_OFF_IRQ_DIS && pwdata[1] |=> !mask_reg[1])
    else $error("disable write did not clear mask bit");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    (mask_reg[`DU_SR_DBGR] && dcc_in.debugger_read_pending) |-> irq)
    else $error("interrupt missing for enabled source");
  a_receive_ready_flag_read: assert property (@(posedge pclk) disable iff (!presetn)
    rhr_rd && !rx_done |=> !receive_ready_flag)
    else $error("receive ready not cleared by read");
  a_err_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    overrun_flag && !(ctrl_wr && pwdata[`DU_B_STA_CLR]) |=> overrun_flag)
    else $error("overrun flag dropped without clear");
  a_err_clear: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_wr && pwdata[`DU_B_STA_CLR] && !rx_done |=> !framing_flag)
    else $error("framing flag not cleared");
  a_transmit_ready_flag_thr: assert property (@(posedge pclk) disable iff (!presetn)
    thr_wr && tx_en_reg && !eng_tx_abort |=> !transmit_ready_flag)
    else $error("transmit ready high after holding write");
  a_local_pin: assert property (@(posedge pclk) disable iff (!presetn)
    channel_loop_select == DU_CH_LOCAL |-> serial_out_pin)
    else $error("output not idle in local loopback");
  a_idle_off: assert property (@(posedge pclk) disable iff (!presetn)
    !tx_en_reg |-> !status[`DU_SR_TXIDLE] && !status[`DU_SR_TRANSMIT_READY_FLAG])
    else $error("idle or ready high with transmitter disabled");
endmodule
`default_nettype wire

// ### logic/dbguart_cfg.svh
// Register offsets, field positions and reset values of the debug UART.
`ifndef DBGUART_CFG_SVH
`define DBGUART_CFG_SVH
`define DU_OFF_CTRL       12'h000
`define DU_OFF_MODE       12'h004
`define DU_OFF_IRQ_EN     12'h008
`define DU_OFF_IRQ_DIS    12'h00c
`define DU_OFF_IRQ_MASK   12'h010
`define DU_OFF_STATUS     12'h014
`define DU_OFF_RX_HOLD    12'h018
`define DU_OFF_TX_HOLD    12'h01c
`define DU_OFF_BAUD       12'h020
`define DU_B_RX_RESET     2
`define DU_B_TX_RESET     3
`define DU_B_RX_EN        4
`define DU_B_RX_DIS       5
`define DU_B_TX_EN        6
`define DU_B_TX_DIS       7
`define DU_B_STA_CLR      8
`define DU_MODE_PAR_LSB   9
`define DU_MODE_CHM_LSB   14
`define DU_SR_RECEIVE_READY_FLAG       0
`define DU_SR_TRANSMIT_READY_FLAG       1
`define DU_SR_RXDONE      3
`define DU_SR_TXDONE      4
`define DU_SR_OVR         5
`define DU_SR_FRM         6
`define DU_SR_CHK         7
`define DU_SR_TXIDLE      9
`define DU_SR_TRANSMIT_BUFFER_EMPTY      11
`define DU_SR_RECEIVE_BUFFER_FULL      12
`define DU_SR_DBGW        30
`define DU_SR_DBGR        31
`define DU_SR_USED        32'hc0001afb
`define DU_MASK_RESET     32'h00000000
`define DU_BAUD_RESET     16'h0000
`define DU_MODE_RESET     3'h0
`endif

// ### logic/dbguart_pkg.sv
// Types shared by the debug UART design files.
`default_nettype none
package dbguart_pkg;
  typedef enum logic [1:0] {
    DU_CH_NORMAL = 2'b00,
    DU_CH_ECHO   = 2'b01,
    DU_CH_LOCAL  = 2'b10,
    DU_CH_REMOTE = 2'b11
  } dbguart_channel_loop_select_e;
  typedef struct packed {
    logic rx_dma_done;
    logic tx_dma_done;
    logic tx_dma_empty;
    logic rx_dma_full;
  } dbguart_dma_s;
  typedef struct packed {
    logic debugger_write_pending;
    logic debugger_read_pending;
  } dbguart_dcc_s;
endpackage
`default_nettype wire

// ### logic/dbguart_baud.sv
// Baud tick generator: one tick per bit sample (16 per bit).
`timescale 1ns/1ps
`default_nettype none
module dbguart_baud (
  input  wire logic        pclk,       // Master clock.
  input  wire logic        presetn,    // Async reset, active low.
  input  wire logic [15:0] divisor,    // Baud divisor.
  output logic             tick        // Sample tick pulse.
);
  logic [15:0] cnt_reg;

  // Divisor 0 stops, 1 ticks each clock, else ticks every divisor clocks
  // so a bit of 16 ticks lasts 16 times the divisor.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_reg <= 16'h0000;
    else if (divisor <= 16'h0001 || cnt_reg >= divisor - 16'h0001)
      cnt_reg <= 16'h0000;
    else
      cnt_reg <= cnt_reg + 16'h0001;
  end

  // A divisor of one gives the master clock itself as the sample clock.
  assign tick = (divisor == 16'h0000) ? 1'b0 :
                (divisor == 16'h0001) ? 1'b1 :
                (cnt_reg >= divisor - 16'h0001);
endmodule
`default_nettype wire

// ### logic/dbguart_serial.sv
// Serial engine: 8 data bits, optional check bit, one stop bit.
`timescale 1ns/1ps
`default_nettype none
module dbguart_serial (
  input  wire logic       pclk,        // Master clock.
  input  wire logic       presetn,     // Async reset, active low.
  input  wire logic       tick,        // Sample tick, 16 per bit.
  input  wire logic [2:0] check_type,  // Check bit type.
  input  wire logic       tx_start,    // Load shifter with tx_data.
  input  wire logic [7:0] tx_data,     // Character to shift out.
  input  wire logic       tx_abort,    // Abort transmission.
  output logic            tx_busy,     // Shifter active.
  output logic            tx_line,     // Transmit line level.
  input  wire logic       rx_line,     // Receive line, synchronised.
  input  wire logic       rx_abort,    // Abort reception.
  output logic            rx_done,     // Character received pulse.
  output logic [7:0]      rx_data,     // Received character.
  output logic            rx_frm_err,  // Framing error with rx_done.
  output logic            rx_chk_err   // Check error with rx_done.
);
  logic [10:0] tsh_reg;
  logic [3:0]  tbit_reg;
  logic [3:0]  tph_reg;
  logic [9:0]  rsh_reg;
  logic [3:0]  rbit_reg;
  logic [3:0]  rph_reg;
  logic        ract_reg;
  logic        use_chk;
  logic [3:0]  nbits;
  logic        tx_chk;
  logic        rx_chk;

  assign use_chk = ~check_type[2];
  assign nbits   = use_chk ? 4'hb : 4'ha;

  function automatic logic chk_bit(input logic [2:0] t,
                                   input logic [7:0] d);
    case (t[1:0])
      2'b00:   chk_bit = ^d;
      2'b01:   chk_bit = ~(^d);
      2'b10:   chk_bit = 1'b0;
      default: chk_bit = 1'b1;
    endcase
  endfunction

  assign tx_chk  = chk_bit(check_type, tx_data);
  assign tx_busy = (tbit_reg != 4'h0);
  assign tx_line = tsh_reg[0];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tsh_reg  <= 11'h7ff;
      tbit_reg <= 4'h0;
      tph_reg  <= 4'h0;
    end
    else if (tx_abort)
    begin
      tsh_reg  <= 11'h7ff;
      tbit_reg <= 4'h0;
    end
    else if (tx_start && !tx_busy)
    begin
      tsh_reg  <= use_chk ? {1'b1, tx_chk, tx_data, 1'b0}
                          : {2'b11, tx_data, 1'b0};
      tbit_reg <= nbits;
      tph_reg  <= 4'h0;
    end
    else if (tx_busy && tick)
    begin
      tph_reg <= tph_reg + 4'h1;
      if (tph_reg == 4'hf)
      begin
        tsh_reg  <= {1'b1, tsh_reg[10:1]};
        tbit_reg <= tbit_reg - 4'h1;
      end
    end
  end

  // Receiver samples the middle of each bit.
  assign rx_chk = chk_bit(check_type, rsh_reg[8:1]);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rsh_reg    <= 10'h000;
      rbit_reg   <= 4'h0;
      rph_reg    <= 4'h0;
      ract_reg   <= 1'b0;
      rx_done    <= 1'b0;
      rx_data    <= 8'h00;
      rx_frm_err <= 1'b0;
      rx_chk_err <= 1'b0;
    end
    else
    begin
      rx_done <= 1'b0;
      if (rx_abort)
      begin
        ract_reg <= 1'b0;
      end
      else if (tick)
      begin
        if (!ract_reg)
        begin
          if (!rx_line)
          begin
            ract_reg <= 1'b1;
            rph_reg  <= 4'h1;
            rbit_reg <= 4'h0;
          end
        end
        else
        begin
          rph_reg <= rph_reg + 4'h1;
          if (rph_reg == 4'h7)
          begin
            if (rbit_reg == 4'h0 && rx_line)
            begin
              ract_reg <= 1'b0;
            end
            else if (rbit_reg == nbits - 4'h1)
            begin
              ract_reg   <= 1'b0;
              rx_done    <= 1'b1;
              rx_data    <= rsh_reg[8:1];
              rx_frm_err <= ~rx_line;
              rx_chk_err <= use_chk && (rsh_reg[9] != rx_chk);
            end
            else
            begin
              rsh_reg  <= use_chk ? {rx_line, rsh_reg[9:1]}
                                  : {1'b0, rx_line, rsh_reg[8:1]};
              rbit_reg <= rbit_reg + 4'h1;
            end
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/dbguart_term.sv
// Serial terminal model: 8 data bits, no check bit, 16 clocks a bit.
`timescale 1ns/1ps
`default_nettype none
module dbguart_term (
  input  wire logic pclk,    // Clock.
  input  wire logic line_in, // Device transmit pin.
  output logic      line_out // Device receive pin.
);
  logic [7:0] rx_byte; // Last captured character.
  initial line_out = 1'b1;
  // Sends one frame; stop low makes a framing fault on purpose.
  task automatic send(input logic [7:0] d, input logic stop);
    for (int i = 0; i < 10; i++)
    begin
      line_out <= i == 0 ? 1'b0 : i == 9 ? stop : d[i-1];
      repeat (16) @(posedge pclk);
    end
    line_out <= 1'b1;
  endtask
  always
  begin
    @(negedge line_in);
    repeat (24) @(posedge pclk);
    for (int i = 0; i < 8; i++)
    begin
      rx_byte[i] = line_in;
      repeat (16) @(posedge pclk);
    end
  end
endmodule
`default_nettype wire

// ### verif/tb.sv
// Self-checking testbench of the debug UART.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb;
  import dbguart_pkg::*;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d, e;} du_row_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, sin, sout;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  dbguart_dma_s dma_in;
  dbguart_dcc_s dcc_in;
  logic err;
  int fail_count, n_tests;
  du_row_s rows [12] = '{
    '{0, 12'h010, 0, 0}, '{0, 12'h020, 0, 0},
    '{1, 12'h008, 32'hffffffff, 0}, '{0, 12'h010, 0, 32'hc0001afb},
    '{1, 12'h00c, 32'h00000003, 0}, '{0, 12'h010, 0, 32'hc0001af8},
    '{0, 12'h014, 0, 32'hc0001818}, '{1, 12'h020, 32'h00000001, 0},
    '{0, 12'h020, 0, 32'h00000001}, '{1, 12'h004, 32'h00000800, 0},
    '{0, 12'h004, 0, 32'h00000800}, '{1, 12'h000, 32'h00000050, 0}};
  dbguart_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .dma_in(dma_in),
    .dcc_in(dcc_in), .serial_in_pin(sin), .serial_out_pin(sout), .irq(irq));
  dbguart_term u_term (.pclk(pclk), .line_in(sout), .line_out(sin));
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial
  begin
    #100us;
    fail_count++;
    complete_run();
  end
  initial
  begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h00000000; dma_in = 4'h0; dcc_in = 2'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1; dma_in <= 4'hf; dcc_in <= 2'h3;
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) `CHK("row", rows[i].e, r)
    end
    `CHK("irq on", 1'b1, irq)
    apb(1, 12'h00c, 32'hffffffff);
    @(posedge pclk);
    `CHK("irq off", 1'b0, irq)
    apb(0, 12'h014, 0);
    `CHK("tx ready idle", 32'hc0001a1a, r)
    apb(0, 12'h030, 0);
    `CHK("unmapped", 1'b1, err)
    apb(1, 12'h01c, 32'h0000013c);
    repeat (200) @(posedge pclk);
    `CHK("tx char", 8'h3c, u_term.rx_byte)
    u_term.send(8'ha5, 1'b1);
    repeat (40) @(posedge pclk);
    apb(0, 12'h014, 0);
    `CHK("rx ready", 1'b1, r[0])
    apb(0, 12'h018, 0);
    `CHK("rx char", 32'h000000a5, r)
    apb(0, 12'h014, 0);
    `CHK("rx ready clr", 1'b0, r[0])
    apb(1, 12'h004, 32'h00000400);
    u_term.send(8'h5a, 1'b1);
    repeat (40) @(posedge pclk);
    apb(0, 12'h014, 0);
    `CHK("chk err", 1'b1, r[7])
    apb(1, 12'h004, 32'h00000800);
    u_term.send(8'h5a, 1'b0);
    repeat (40) @(posedge pclk);
    apb(0, 12'h014, 0);
    apb(0, 12'h014, 0);
    `CHK("frame sticky", 1'b1, r[6])
    apb(1, 12'h000, 32'h00000100);
    apb(0, 12'h014, 0);
    `CHK("err clear", 3'h0, r[7:5])
    apb(1, 12'h000, 32'h00000004);
    apb(0, 12'h014, 0);
    `CHK("rx off", 1'b0, r[0])
    apb(1, 12'h000, 32'h00000010);
    apb(1, 12'h004, 32'h00008000);
    apb(1, 12'h01c, 32'h00000069);
    repeat (100) @(posedge pclk);
    `CHK("loop pin", 1'b1, sout)
    repeat (100) @(posedge pclk);
    apb(0, 12'h018, 0);
    `CHK("loop char", 32'h00000069, r)
    apb(1, 12'h004, 32'h00004800);
    u_term.send(8'hc3, 1'b1);
    `CHK("echo out", 8'hc3, u_term.rx_byte)
    apb(0, 12'h018, 0);
    `CHK("echo in", 32'h000000c3, r)
    apb(1, 12'h004, 32'h0000c800);
    u_term.send(8'h96, 1'b1);
    `CHK("remote out", 8'h96, u_term.rx_byte)
    apb(0, 12'h014, 0);
    `CHK("remote rx off", 1'b0, r[0])
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK("reset irq", 1'b0, irq)
    presetn <= 1'b1;
    apb(0, 12'h010, 0);
    `CHK("reset mask", 32'h00000000, r)
    apb(0, 12'h004, 0);
    `CHK("reset mode", 32'h00000000, r)
    complete_run();
  end
endmodule
`default_nettype wire
